// File: design/dera_map.svh
`ifndef DERA_MAP_SVH
`define DERA_MAP_SVH
`define DERA_ADDR_DMA0_SEL01 16'h1c1a
`define DERA_ADDR_DMA0_SEL23 16'h1c1b
`define DERA_ADDR_DMA1_SEL01 16'h1c1c
`define DERA_ADDR_DMA1_SEL23 16'h1c1d
`define DERA_ADDR_FLAGS 16'h1c30
`define DERA_ADDR_ENABLES 16'h1c31
`define DERA_ADDR_DMA2_SEL01 16'h1c36
`define DERA_ADDR_DMA2_SEL23 16'h1c37
`define DERA_ADDR_DMA3_SEL01 16'h1c38
`define DERA_ADDR_DMA3_SEL23 16'h1c39
`define DERA_SEL_LO_LSB 0
`define DERA_SEL_HI_LSB 8
`define DERA_SEL_RESET 4'h0
`define DERA_REG_RESET 16'h0000
`define DERA_CODE_SRC1 4'h1
`define DERA_CODE_SRC2 4'h2
`define DERA_CODE_SRC3 4'h3
`define DERA_CODE_SRC4 4'h4
`define DERA_CODE_SRC5 4'h5
`define DERA_CODE_SRC6 4'h6
`define DERA_CODE_SRC7 4'h7
`define DERA_CODE_SRC8 4'h8
`define DERA_CODE_TIMER0 4'hc
`define DERA_CODE_TIMER1 4'hd
`define DERA_CODE_TIMER2 4'he
`endif

// File: design/dera_pkg.sv
package dera_pkg;
    typedef logic [3:0] dera_sel_type;
    typedef logic [15:0] dera_word_type;
    // Peripheral event bits presented to the router
    typedef enum logic [19:0] {
        DERA_EV_ASP_A_TX = 20'h00001,
        DERA_EV_ASP_A_RX = 20'h00002,
        DERA_EV_ASP_B_TX = 20'h00004,
        DERA_EV_ASP_B_RX = 20'h00008,
        DERA_EV_ASP_C_TX = 20'h00010,
        DERA_EV_ASP_C_RX = 20'h00020,
        DERA_EV_ASP_D_TX = 20'h00040,
        DERA_EV_ASP_D_RX = 20'h00080,
        DERA_EV_CARD_A_TX = 20'h00100,
        DERA_EV_CARD_A_RX = 20'h00200,
        DERA_EV_CARD_B_TX = 20'h00400,
        DERA_EV_CARD_B_RX = 20'h00800,
        DERA_EV_UART_TX = 20'h01000,
        DERA_EV_UART_RX = 20'h02000,
        DERA_EV_I2C_TX = 20'h04000,
        DERA_EV_I2C_RX = 20'h08000,
        DERA_EV_CONVERTER = 20'h10000,
        DERA_EV_TIMER0 = 20'h20000,
        DERA_EV_TIMER1 = 20'h40000,
        DERA_EV_TIMER2 = 20'h80000
    } dera_event_type;
endpackage

// File: design/dera_event_route_irq.sv
// What this block does
// - Twenty event sources; every channel picks its own source independently.
// - Each controller has a low-pair and a high-pair event select register.
// - Low pair: channel 0 in bits 3:0, channel 1 in 11:8, rest zero.
// - Routed event paces a channel only while its pacing bit is one.
// - Several channels may select and share the same event.
// - Codes c, d, e route timers 0, 1, 2 on every controller.
// - Codes 0, 9 to b and f route nothing.
// - Controller 0: serial port a, then card interfaces a and b.
// - Controller 1: serial port c at 1,2; UART at 5,6.
// - Controller 2: I2C at 1,2; converter at 3; serial port d at 4,5.
// - Controller 3: serial port b at 1,2; codes 3 to 8 reserved.
// - Completed block with its enable set requests a CPU interrupt.
// - All sixteen channel interrupts merge into one line.
// - Completion sets a held flag; writing one clears, zero leaves it.
// - Flag bit four times controller plus channel; one means complete.
// - Enable register uses the flag mapping; resets to zero.
// - High pair: channel 2 in bits 3:0, channel 3 in 11:8, rest zero.
`timescale 1ns/1ps
`default_nettype none
`include "dera_map.svh"

module dera_event_route_irq #(
    parameter int NUM_CTRL = 4,
    parameter int NUM_CHAN = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register port, 16-bit word addressed I/O space
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_wdata,
    output logic [15:0] io_rdata,
    // Peripheral and timer events, one bit per source
    input wire logic [19:0] periph_events,
    // Per-channel pacing bit and completion pulse from the controllers
    input wire logic [15:0] event_pacing_on,
    input wire logic [15:0] channel_done,
    // Paced sync event per channel and aggregated interrupt
    output logic [15:0] channel_sync_event,
    output logic dma_irq
);

    if (NUM_CTRL != 4 || NUM_CHAN != 4)
    begin : g_size_check
        $error("dera_event_route_irq serves exactly four controllers of four channels");
    end

    logic rst_meta;
    logic rst_n;
    logic [19:0] ev_meta;
    logic [19:0] ev_sync;
    dera_pkg::dera_sel_type chan_sel [16];
    dera_pkg::dera_word_type dma_completion_flags;
    dera_pkg::dera_word_type dma_completion_irq_enables;
    logic [15:0] next_sync;
    logic [15:0] next_rdata;
    logic [4:0] sel_dec;

    // Reset release through two stages
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Event pins come from other domains
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_meta <= 20'h00000;
            ev_sync <= 20'h00000;
        end
        else
        begin
            ev_meta <= periph_events;
            ev_sync <= ev_meta;
        end
    end

    // Source table per controller; unlisted codes route nothing
    function automatic logic route(input logic [1:0] ctrl, input dera_pkg::dera_sel_type code,
                                   input logic [19:0] ev);
        logic r;
        r = 1'b0;
        case (code)
            `DERA_CODE_TIMER0: r = ev[17];
            `DERA_CODE_TIMER1: r = ev[18];
            `DERA_CODE_TIMER2: r = ev[19];
            default:
            begin
                case (ctrl)
                    2'h0:
                    begin
                        case (code)
                            `DERA_CODE_SRC1: r = ev[0];
                            `DERA_CODE_SRC2: r = ev[1];
                            `DERA_CODE_SRC5: r = ev[8];
                            `DERA_CODE_SRC6: r = ev[9];
                            `DERA_CODE_SRC7: r = ev[10];
                            `DERA_CODE_SRC8: r = ev[11];
                            default: r = 1'b0;
                        endcase
                    end
                    2'h1:
                    begin
                        case (code)
                            `DERA_CODE_SRC1: r = ev[4];
                            `DERA_CODE_SRC2: r = ev[5];
                            `DERA_CODE_SRC5: r = ev[12];
                            `DERA_CODE_SRC6: r = ev[13];
                            default: r = 1'b0;
                        endcase
                    end
                    2'h2:
                    begin
                        case (code)
                            `DERA_CODE_SRC1: r = ev[14];
                            `DERA_CODE_SRC2: r = ev[15];
                            `DERA_CODE_SRC3: r = ev[16];
                            `DERA_CODE_SRC4: r = ev[6];
                            `DERA_CODE_SRC5: r = ev[7];
                            default: r = 1'b0;
                        endcase
                    end
                    default:
                    begin
                        case (code)
                            `DERA_CODE_SRC1: r = ev[2];
                            `DERA_CODE_SRC2: r = ev[3];
                            default: r = 1'b0;
                        endcase
                    end
                endcase
            end
        endcase
        return r;
    endfunction

    // Each channel looks up its own select independently
    always_comb
    begin
        next_sync = 16'h0000;
        for (int i = 0; i < 16; i++)
            next_sync[i] = event_pacing_on[i]
                && route(2'(i / 4), chan_sel[i], ev_sync);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            channel_sync_event <= 16'h0000;
        else
            channel_sync_event <= next_sync;
    end

    // Select register writes: low pair holds channels 0,1; high pair 2,3
    function automatic logic [4:0] sel_decode(input logic [15:0] a);
        logic [4:0] d;
        d = 5'h00;
        case (a)
            `DERA_ADDR_DMA0_SEL01: d = 5'h10;
            `DERA_ADDR_DMA0_SEL23: d = 5'h11;
            `DERA_ADDR_DMA1_SEL01: d = 5'h12;
            `DERA_ADDR_DMA1_SEL23: d = 5'h13;
            `DERA_ADDR_DMA2_SEL01: d = 5'h14;
            `DERA_ADDR_DMA2_SEL23: d = 5'h15;
            `DERA_ADDR_DMA3_SEL01: d = 5'h16;
            `DERA_ADDR_DMA3_SEL23: d = 5'h17;
            default: d = 5'h00;
        endcase
        return d;
    endfunction

    assign sel_dec = sel_decode(io_addr);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 16; i++)
                chan_sel[i] <= `DERA_SEL_RESET;
        end
        else if (io_wr && sel_dec[4])
        begin
            // Index of register: controller*2 + pair; channel base = index*2
            chan_sel[{sel_dec[2:0], 1'b0}] <=
                io_wdata[`DERA_SEL_LO_LSB +: 4];
            chan_sel[{sel_dec[2:0], 1'b1}] <=
                io_wdata[`DERA_SEL_HI_LSB +: 4];
        end
    end

    // Flags: set wins over write-one-clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            dma_completion_flags <= `DERA_REG_RESET;
        else if (io_wr && io_addr == `DERA_ADDR_FLAGS)
            dma_completion_flags <= (dma_completion_flags & ~io_wdata)
                | channel_done;
        else
            dma_completion_flags <= dma_completion_flags | channel_done;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            dma_completion_irq_enables <= `DERA_REG_RESET;
        else if (io_wr && io_addr == `DERA_ADDR_ENABLES)
            dma_completion_irq_enables <= io_wdata;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            dma_irq <= 1'b0;
        else
            dma_irq <= |(dma_completion_flags & dma_completion_irq_enables);
    end

    // Read data; reserved bits and unmapped addresses read zero
    always_comb
    begin
        next_rdata = 16'h0000;
        if (io_addr == `DERA_ADDR_FLAGS)
            next_rdata = dma_completion_flags;
        else if (io_addr == `DERA_ADDR_ENABLES)
            next_rdata = dma_completion_irq_enables;
        else if (sel_dec[4])
        begin
            next_rdata[`DERA_SEL_LO_LSB +: 4] = chan_sel[{sel_dec[2:0], 1'b0}];
            next_rdata[`DERA_SEL_HI_LSB +: 4] = chan_sel[{sel_dec[2:0], 1'b1}];
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            io_rdata <= 16'h0000;
        else if (io_rd)
            io_rdata <= next_rdata;
    end

    // Checks
    a_flag_sets_on_done: assert property (@(posedge mclk) disable iff (!rst_n)
        channel_done[0] |=> dma_completion_flags[0])
        else $error("flag 0 not set after completion");
    a_clear_collision_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
        (io_wr && io_addr == `DERA_ADDR_FLAGS && io_wdata[5] && channel_done[5])
        |=> dma_completion_flags[5])
        else $error("completion lost in clear collision");
    a_clear_one_works: assert property (@(posedge mclk) disable iff (!rst_n)
        (io_wr && io_addr == `DERA_ADDR_FLAGS && io_wdata[3] && !channel_done[3])
        |=> !dma_completion_flags[3])
        else $error("write one did not clear flag");
    a_write_zero_holds: assert property (@(posedge mclk) disable iff (!rst_n)
        (io_wr && io_addr == `DERA_ADDR_FLAGS && !io_wdata[9] && dma_completion_flags[9])
        |=> dma_completion_flags[9])
        else $error("write zero changed flag");
    a_irq_follows_pair: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 dma_irq == $past(|(dma_completion_flags & dma_completion_irq_enables)))
        else $error("interrupt does not match flags and enables");
    a_irq_masked_off: assert property (@(posedge mclk) disable iff (!rst_n)
        (dma_completion_irq_enables == 16'h0000)[*2] |-> !dma_irq)
        else $error("interrupt with all enables clear");
    a_sync_needs_pacing: assert property (@(posedge mclk) disable iff (!rst_n)
        !event_pacing_on[6] |=> !channel_sync_event[6])
        else $error("sync event without pacing");
    a_timer_route: assert property (@(posedge mclk) disable iff (!rst_n)
        (event_pacing_on[10] && chan_sel[10] == `DERA_CODE_TIMER1 && ev_sync[18])
        |=> channel_sync_event[10])
        else $error("timer 1 not routed");
    a_reserved_silent: assert property (@(posedge mclk) disable iff (!rst_n)
        (chan_sel[1] == 4'hf || chan_sel[1] == 4'h0) |=> !channel_sync_event[1])
        else $error("reserved code routed an event");
    a_sel_readback: assert property (@(posedge mclk) disable iff (!rst_n)
        (io_rd && io_addr == `DERA_ADDR_DMA1_SEL23) |=> io_rdata[15:12] == 4'h0
        && io_rdata[7:4] == 4'h0)
        else $error("reserved select bits not zero");
    a_irq_on_pair: assert property (@(posedge mclk) disable iff (!rst_n)
        (|(dma_completion_flags & dma_completion_irq_enables)) |=> dma_irq)
        else $error("enabled completion raised no interrupt");
    a_sel_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
        (io_wr && io_addr == `DERA_ADDR_DMA2_SEL01)
        |=> chan_sel[9] == $past(io_wdata[`DERA_SEL_HI_LSB +: 4]))
        else $error("select write missed its channel");

endmodule // dera_event_route_irq
`default_nettype wire

// File: tb/dera_far_side.sv
`timescale 1ns/1ps
`default_nettype none

module dera_far_side (
    // Clock
    input wire logic mclk,
    // Controllers and event sources toward the router
    output logic [19:0] periph_events,
    output logic [15:0] event_pacing_on,
    output logic [15:0] channel_done
);
    initial
    begin
        periph_events = '0;
        event_pacing_on = '0;
        channel_done = '0;
    end
    // A completion lasts one clock
    task automatic pulse_done(input logic [15:0] m);
        @(posedge mclk);
        channel_done <= m;
        @(posedge mclk);
        channel_done <= '0;
    endtask
    task automatic set_events(input logic [19:0] v);
        @(posedge mclk);
        periph_events <= v;
    endtask
    task automatic set_pacing(input logic [15:0] v);
        @(posedge mclk);
        event_pacing_on <= v;
    endtask
endmodule // dera_far_side
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dera_map.svh"

module testbench;
    logic mclk;
    logic reset_n;
    logic [15:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [15:0] io_wdata;
    logic [15:0] io_rdata;
    logic [19:0] periph_events;
    logic [15:0] event_pacing_on;
    logic [15:0] channel_done;
    logic [15:0] channel_sync_event;
    logic dma_irq;
    logic rd_seen;
    logic [15:0] exp_q[$];
    logic [15:0] r;
    logic [15:0] e;
    int err_total;
    int comparisons;
    int seed;
    int b;
    localparam logic [15:0] reg_addr[10] = '{`DERA_ADDR_DMA0_SEL01, `DERA_ADDR_DMA0_SEL23,
        `DERA_ADDR_DMA1_SEL01, `DERA_ADDR_DMA1_SEL23, `DERA_ADDR_FLAGS, `DERA_ADDR_ENABLES,
        `DERA_ADDR_DMA2_SEL01, `DERA_ADDR_DMA2_SEL23, `DERA_ADDR_DMA3_SEL01,
        `DERA_ADDR_DMA3_SEL23};
    localparam int sel_idx[8] = '{0, 1, 2, 3, 6, 7, 8, 9};
    // Event bit per controller for codes 0 to 8, -1 where nothing is routed
    localparam int route_tbl[4][9] = '{'{-1, 0, 1, -1, -1, 8, 9, 10, 11},
        '{-1, 4, 5, -1, -1, 12, 13, -1, -1}, '{-1, 14, 15, 16, 6, 7, -1, -1, -1},
        '{-1, 2, 3, -1, -1, -1, -1, -1, -1}};

    dera_event_route_irq uut (
        .mclk(mclk), .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .periph_events(periph_events),
        .event_pacing_on(event_pacing_on), .channel_done(channel_done),
        .channel_sync_event(channel_sync_event), .dma_irq(dma_irq)
    );
    dera_far_side far (
        .mclk(mclk), .periph_events(periph_events), .event_pacing_on(event_pacing_on),
        .channel_done(channel_done)
    );

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input logic [19:0] seen, input logic [19:0] want);
        comparisons++;
        if (seen !== want)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge mclk);
        io_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] want);
        @(posedge mclk);
        io_addr <= a;
        io_rd <= 1'b1;
        exp_q.push_back(want);
        @(posedge mclk);
        io_rd <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Read data is registered: compare one edge after the read was taken
    always @(posedge mclk)
    begin
        if (rd_seen === 1'b1 && exp_q.size() > 0)
            check(io_rdata, exp_q.pop_front());
        rd_seen <= io_rd;
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        $display("unexpected at %0t: run too long", $time);
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        seed = 17239;
        err_total = 0;
        comparisons = 0;
        reset_n = 1'b0;
        io_addr = '0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = '0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 10; i++)
            rd(reg_addr[i], 16'h0000);
        #1 check(dma_irq, 1'b0);
        for (int i = 0; i < 10; i++)
        begin
            r = 16'($random(seed));
            if (i != 4)
            begin
                wr(reg_addr[i], r);
                rd(reg_addr[i], r & ((i == 5) ? 16'hffff : 16'h0f0f));
            end
        end
        wr(16'h1c20, 16'hffff);
        rd(16'h1c20, 16'h0000);
        wr(reg_addr[5], 16'h0000);
        r = 16'($random(seed)) | 16'h0001;
        far.pulse_done(r);
        repeat (2) @(posedge mclk);
        rd(reg_addr[4], r);
        #1 check(dma_irq, 1'b0);
        wr(reg_addr[4], 16'h0000);
        rd(reg_addr[4], r);
        e = 16'($random(seed));
        wr(reg_addr[5], e);
        repeat (2) @(posedge mclk);
        #1 check(dma_irq, |(r & e));
        wr(reg_addr[5], r);
        repeat (2) @(posedge mclk);
        #1 check(dma_irq, 1'b1);
        // Completion lands on the same edge as the clear
        fork
            wr(reg_addr[4], r);
            far.pulse_done(16'h0001);
        join
        rd(reg_addr[4], 16'h0001);
        wr(reg_addr[4], 16'h0001);
        repeat (2) @(posedge mclk);
        #1 check(dma_irq, 1'b0);
        rd(reg_addr[4], 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            for (int code = 0; code < 16; code++)
            begin
                r = {4'h0, code[3:0], 4'h0, code[3:0]};
                wr(reg_addr[sel_idx[2 * c]], r);
                wr(reg_addr[sel_idx[2 * c + 1]], r);
                e = 16'(($random(seed) & 15) | 5) << (4 * c);
                far.set_pacing(e);
                b = (code <= 8) ? route_tbl[c][code] : ((code >= 12 && code <= 14) ? code + 5 : -1);
                far.set_events((b < 0) ? 20'hfffff : 20'h1 << b);
                repeat (4) @(posedge mclk);
                #1 check(channel_sync_event, (b < 0) ? 16'h0000 : e);
                if (b >= 0)
                begin
                    far.set_events(~(20'h1 << b));
                    repeat (4) @(posedge mclk);
                    #1 check(channel_sync_event, 16'h0000);
                end
            end
        end
        repeat (3) @(posedge mclk);
        if (exp_q.size() != 0)
        begin
            $display("unexpected at %0t: reads left unanswered", $time);
            err_total++;
        end
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
